// file: src/epi_unit.sv
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R01] pin activity interrupts even when the pin is driven as an output
// [R02] enabled low-level channel requests as long as the pin is low
// [R03] edge detection only while the I/O clock runs
// [R04] low level detected without the I/O clock, can wake from deep sleep
// [R05] I/O clock stopped in all sleep modes but idle; only level wakes
// [R06] power-down level wake needs two watchdog-clock samples
// [R07] wake if level seen in sampling or held to end of start-up
// [R08] level lost before start-up end: wake, but no request
// [R09] channel fires only with global enable and its own enable bit; edges still set irq_status (IRQ) without them
// [R10] pin sampled before edge detection; pulses over one clock caught
// [R11] source holds low level until the current instruction completes
// [R12] channel b sense at bits 3:2: low, any, fall, rise
// [R13] channel a sense at bits 1:0 with the same encoding
// [R14] bit 7 enables channel b, bit 6 enables channel a
// [R15] each channel has its own request output (vector)
// [R16] flag sets on event, clears on vector entry or write one
// [R17] flag reads cleared while channel is in low-level mode
// [R18] edges found by comparing current and previous synced samples
module epi_unit #(
    parameter int STARTUP_NS = epi_pkg::STARTUP_NS_DEFAULT
) (
    input  wire logic        SYS_CLK,      // system clock, 40 MHz
    input  wire logic        RESETN,       // async reset, active low
    input  wire logic        PSEL,         // apb select
    input  wire logic        PENABLE,      // apb access phase
    input  wire logic        PWRITE,       // apb direction
    input  wire logic [7:0]  PADDR,        // apb byte address
    input  wire logic [31:0] PWDATA,       // apb write data
    output logic      [31:0] PRDATA,       // apb read data
    output logic             PREADY,       // apb ready
    output logic             PSLVERR,      // apb error on unmapped address
    input  wire logic        EXT_IRQ_PIN_A, // pin value, as seen at the pad
    input  wire logic        EXT_IRQ_PIN_B, // pin value, as seen at the pad
    input  wire logic        IO_CLK_RUN,   // i/o clock running (not deep sleep)
    input  wire logic        POWER_DOWN,   // part is in power-down
    input  wire logic        WDT_TICK,     // one pulse per watchdog osc period
    input  wire logic [1:0]  VECTOR_ACK,   // core entered vector a(0) / b(1)
    output logic      [1:0]  VECTOR_REQ,   // request to core, a(0) / b(1)
    output logic             WAKE_UP,      // wake request to power control
    output logic             IRQ           // summary interrupt, level
);
    import epi_pkg::*;

    localparam int STARTUP_CYC_RAW = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_CYC = (STARTUP_CYC_RAW < 1) ? 1 : STARTUP_CYC_RAW;
    localparam int SC_W = $clog2(STARTUP_CYC + 1);

    function automatic logic sense_hit(input logic [1:0] sense,
                                       input logic       cur,
                                       input logic       prev);
        unique case (epi_sense_type'(sense))
            EPI_SENSE_LOW:  sense_hit = 1'b0;
            EPI_SENSE_ANY:  sense_hit = cur ^ prev;
            EPI_SENSE_FALL: sense_hit = prev & ~cur;
            EPI_SENSE_RISE: sense_hit = cur & ~prev;
        endcase
    endfunction : sense_hit

    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    logic [7:0]  sense_and_sleep_control;
    logic [7:0]  external_irq_enable_control;
    logic [7:0]  core_status_word;
    logic [1:0]  req_flag;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [1:0]  sync1, sync2, prev;
    logic [1:0]  wake_cnt;
    logic [SC_W-1:0] su_cnt;
    logic        su_active;
    logic [31:0] rdata;
    logic        ready, slverr, irq_out, wake_out;
    logic [1:0]  vreq;

    logic [7:0]  next_sense, next_enable, next_core;
    logic [1:0]  next_flag, next_status, next_mask, next_sync1, next_sync2, next_prev;
    logic [1:0]  next_wake_cnt;
    logic [SC_W-1:0] next_su_cnt;
    logic        next_su_active;
    logic [31:0] next_rdata;
    logic        next_ready, next_slverr, next_irq, next_wake;
    logic [1:0]  next_vreq;

    logic [1:0]  pins, sense [2], chan_en, level_low, edge_hit, is_level;
    logic        access, wr, gie, hold_off;
    logic [7:0]  flag_view;

    // ----------------------------------------
    // per-channel decode
    // ----------------------------------------
    always_comb begin
        pins     = {EXT_IRQ_PIN_B, EXT_IRQ_PIN_A};  // [R01]
        sense[0] = sense_and_sleep_control[CHAN_A_SENSE_LSB +: 2];  // [R13]
        sense[1] = sense_and_sleep_control[CHAN_B_SENSE_LSB +: 2];  // [R12]
        gie      = core_status_word[GLOBAL_IE_BIT];
        // no level request before wake is confirmed or while start-up runs
        hold_off = su_active | (POWER_DOWN & ~wake_out);  // [R08]
        chan_en  = {external_irq_enable_control[CHAN_B_ENABLE],
                    external_irq_enable_control[CHAN_A_ENABLE]} & {2{gie}};  // [R09] [R14]
        for (int i = 0; i < 2; i++) begin
            is_level[i]  = epi_sense_type'(sense[i]) == EPI_SENSE_LOW;
            // level path reads the raw pin: no i/o clock needed
            level_low[i] = is_level[i] & ~pins[i];  // [R04]
            // edges only from synced samples while i/o clock runs
            edge_hit[i]  = IO_CLK_RUN & sense_hit(sense[i], sync2[i], prev[i]);  // [R03] [R05] [R10] [R18]
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    always_comb begin
        access = PSEL & PENABLE & ready;
        wr     = access & PWRITE;
        flag_view = {req_flag[1] & ~is_level[1], req_flag[0] & ~is_level[0], 6'h00};  // [R17]
        next_sense  = sense_and_sleep_control;
        next_enable = external_irq_enable_control;
        next_core   = core_status_word;
        next_mask   = irq_mask;
        next_rdata  = rdata;
        next_slverr = 1'b0;
        // one wait state: ready pulses in access phase, drops after
        next_ready  = PSEL & PENABLE & ~ready;
        if (PSEL & PENABLE & ~ready) begin
            next_rdata = 32'h0000_0000;
            unique case (PADDR)
                ADDR_SENSE_CTRL:  next_rdata[7:0] = sense_and_sleep_control;
                ADDR_ENABLE_CTRL: next_rdata[7:0] = external_irq_enable_control;
                ADDR_FLAGS:       next_rdata[7:0] = flag_view;
                ADDR_CORE_STATUS: next_rdata[7:0] = core_status_word;
                ADDR_IRQ_STATUS:  next_rdata[1:0] = irq_status;
                ADDR_IRQ_MASK:    next_rdata[1:0] = irq_mask;
                ADDR_WAKE_CTRL:   next_rdata[1:0] = {su_active, WAKE_UP};
                default:          next_slverr = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (PADDR)
                ADDR_SENSE_CTRL:  next_sense  = PWDATA[7:0];
                // reserved bits 5:2 read zero
                ADDR_ENABLE_CTRL: next_enable = {PWDATA[7:6], 4'h0,
                                                 PWDATA[ENABLE_CTRL_MASK_LO-1:0]};
                ADDR_CORE_STATUS: next_core   = PWDATA[7:0];
                ADDR_IRQ_MASK:    next_mask   = PWDATA[1:0];
                default:          next_mask   = irq_mask;
            endcase
        end
    end

    // ----------------------------------------
    // request flags, vectors, summary irq
    // ----------------------------------------
    always_comb begin
        next_sync1 = pins;
        next_sync2 = sync1;
        next_prev  = sync2;
        next_flag  = req_flag;
        next_status = irq_status;
        for (int i = 0; i < 2; i++) begin
            if (VECTOR_ACK[i])
                next_flag[i] = 1'b0;  // [R16]
            if (wr && PADDR == ADDR_FLAGS && PWDATA[CHAN_A_FLAG + i])
                next_flag[i] = 1'b0;  // [R16]
            if (wr && PADDR == ADDR_IRQ_STATUS && PWDATA[i])
                next_status[i] = 1'b0;
            // set wins over any clear in the same cycle
            if (edge_hit[i]) begin
                next_flag[i]   = 1'b1;  // [R16]
                next_status[i] = 1'b1;
            end
            if (is_level[i])
                next_flag[i] = 1'b0;  // [R17]
            if (chan_en[i] & level_low[i] & ~hold_off)
                next_status[i] = 1'b1;
        end
        // level requests follow the pin; edge requests follow the flag
        for (int i = 0; i < 2; i++) begin
            next_vreq[i] = chan_en[i] & (is_level[i] ? (level_low[i] & ~hold_off)  // [R02] [R08]
                                                     : next_flag[i]);  // [R15]
        end
        next_irq = |(next_status & irq_mask);
    end

    // ----------------------------------------
    // power-down wake filter
    // ----------------------------------------
    always_comb begin
        logic any_low;
        any_low        = |(level_low & chan_en);  // [R04]
        next_wake_cnt  = wake_cnt;
        next_su_cnt    = su_cnt;
        next_su_active = su_active;
        next_wake      = wake_out;
        // window runs out even if power-down ends early,
        // else level requests would stay suppressed for good
        if (su_active) begin
            if (su_cnt == SC_W'(1)) begin
                next_su_active = 1'b0;  // [R07]
            end
            next_su_cnt = su_cnt - SC_W'(1);
        end
        if (!POWER_DOWN) begin
            next_wake_cnt = 2'h0;
            next_wake     = 1'b0;
        end else if (!su_active && !wake_out && WDT_TICK) begin
            // two consecutive watchdog samples filter noise
            if (any_low) begin
                next_wake_cnt = wake_cnt + 2'h1;  // [R06]
                if (wake_cnt == 2'(WAKE_SAMPLES - 1)) begin
                    next_wake      = 1'b1;  // [R07]
                    next_su_active = 1'b1;
                    next_su_cnt    = SC_W'(STARTUP_CYC);
                end
            end else begin
                next_wake_cnt = 2'h0;
            end
        end
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sense_and_sleep_control     <= SENSE_CTRL_RESET;
            external_irq_enable_control <= ENABLE_CTRL_RESET;
            core_status_word            <= CORE_STATUS_RESET;
            irq_mask   <= IRQ_MASK_RESET;
            irq_status <= 2'h0;
            req_flag   <= 2'h0;
            sync1      <= 2'h3;
            sync2      <= 2'h3;
            prev       <= 2'h3;
            wake_cnt   <= 2'h0;
            su_cnt     <= '0;
            su_active  <= 1'b0;
            rdata      <= 32'h0000_0000;
            ready      <= 1'b0;
            slverr     <= 1'b0;
            irq_out    <= 1'b0;
            wake_out   <= 1'b0;
            vreq       <= 2'h0;
        end else begin
            sense_and_sleep_control     <= next_sense;
            external_irq_enable_control <= next_enable;
            core_status_word            <= next_core;
            irq_mask   <= next_mask;
            irq_status <= next_status;
            req_flag   <= next_flag;
            sync1      <= next_sync1;
            sync2      <= next_sync2;
            prev       <= next_prev;
            wake_cnt   <= next_wake_cnt;
            su_cnt     <= next_su_cnt;
            su_active  <= next_su_active;
            rdata      <= next_rdata;
            ready      <= next_ready;
            slverr     <= next_slverr;
            irq_out    <= next_irq;
            wake_out   <= next_wake;
            vreq       <= next_vreq;
        end
    end

    assign PRDATA     = rdata;
    assign PREADY     = ready;
    // slverr is only ever set for the cycle in which ready stands
    assign PSLVERR    = slverr;
    assign IRQ        = irq_out;
    assign WAKE_UP    = wake_out;
    assign VECTOR_REQ = vreq;

endmodule : epi_unit
`default_nettype wire

// file: src/epi_pkg.sv
package epi_pkg;
    // ----------------------------------------
    // register word offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_SENSE_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_ENABLE_CTRL = 8'h04;
    localparam logic [7:0] ADDR_FLAGS       = 8'h08;
    localparam logic [7:0] ADDR_CORE_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h14;
    localparam logic [7:0] ADDR_WAKE_CTRL   = 8'h18;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CHAN_A_SENSE_LSB = 0;
    localparam int CHAN_B_SENSE_LSB = 2;
    localparam int CHAN_A_ENABLE    = 6;
    localparam int CHAN_B_ENABLE    = 7;
    localparam int CHAN_A_FLAG      = 6;
    localparam int CHAN_B_FLAG      = 7;
    localparam int GLOBAL_IE_BIT    = 7;
    localparam int ENABLE_CTRL_MASK_LO = 2;
    // ----------------------------------------
    // reset values and timing
    // ----------------------------------------
    localparam logic [7:0] SENSE_CTRL_RESET  = 8'h00;
    localparam logic [7:0] ENABLE_CTRL_RESET = 8'h00;
    localparam logic [7:0] CORE_STATUS_RESET = 8'h00;
    localparam logic [1:0] IRQ_MASK_RESET    = 2'h0;
    localparam int WAKE_SAMPLES = 2;
    localparam int STARTUP_NS_DEFAULT = 4000;
    localparam int CLK_PERIOD_NS = 25;

    typedef enum logic [1:0] {
        EPI_SENSE_LOW,
        EPI_SENSE_ANY,
        EPI_SENSE_FALL,
        EPI_SENSE_RISE
    } epi_sense_type;
endpackage : epi_pkg

// file: dv/epi_unit_checker.sv
`timescale 1ns/1ps
`default_nettype none
module epi_unit_checker
    import epi_pkg::*;
#(parameter int STARTUP_NS = epi_pkg::STARTUP_NS_DEFAULT) (
    input wire logic        SYS_CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA, PRDATA,
    input wire logic        EXT_IRQ_PIN_A, EXT_IRQ_PIN_B, IO_CLK_RUN, POWER_DOWN, WDT_TICK,
    input wire logic [1:0]  VECTOR_ACK, VECTOR_REQ,
    input wire logic        WAKE_UP, IRQ
);
    // ----------------------------------------
    // shadow of the written control state
    // ----------------------------------------
    // start-up window may outlast power-down by its full length
    localparam int QUIET_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
    logic [7:0] sense;
    logic [7:0] enab;
    logic       gie;
    logic [1:0] msk;
    logic [7:0] quiet;
    wire wr = PSEL && PENABLE && PREADY && PWRITE;
    wire rd = PSEL && PENABLE && PREADY && !PWRITE;
    wire ok_a = enab[CHAN_A_ENABLE] && gie;
    wire lvl_a = ok_a && sense[1:0] == EPI_SENSE_LOW && quiet == 8'(QUIET_CYC);
    wire any_msk = |msk;
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sense <= '0;
            enab <= '0;
            gie <= 1'b0;
            msk <= '0;
            quiet <= '0;
        end else begin
            if (wr && PADDR == ADDR_SENSE_CTRL) sense <= PWDATA[7:0];
            if (wr && PADDR == ADDR_ENABLE_CTRL) enab <= PWDATA[7:0];
            if (wr && PADDR == ADDR_CORE_STATUS) gie <= PWDATA[GLOBAL_IE_BIT];
            if (wr && PADDR == ADDR_IRQ_MASK) msk <= PWDATA[1:0];
            // start-up window must be long over before level requests are judged
            if (POWER_DOWN) quiet <= '0;
            else if (quiet != 8'(QUIET_CYC)) quiet <= quiet + 8'h01;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    ready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready late");
    unmapped_err_a: assert property (PREADY && PADDR > ADDR_WAKE_CTRL |->
        PSLVERR && (PWRITE || PRDATA == '0)) else $error("unmapped access not refused");
    sense_read_a: assert property (rd && PADDR == ADDR_SENSE_CTRL |-> PRDATA == {24'h0, sense})
        else $error("sense readback wrong");
    enable_read_a: assert property (rd && PADDR == ADDR_ENABLE_CTRL |->
        PRDATA[7:6] == enab[7:6] && PRDATA[5:2] == 4'h0) else $error("enable readback wrong");
    flag_low_a: assert property (rd && PADDR == ADDR_FLAGS && sense[1:0] == EPI_SENSE_LOW
        |-> !PRDATA[CHAN_A_FLAG]) else $error("flag set in level mode");
    gate_a: assert property (VECTOR_REQ[0] |-> $past(ok_a) || $past(ok_a, 2))
        else $error("request without enables");
    level_req_a: assert property (lvl_a && !EXT_IRQ_PIN_A ##1 lvl_a && !EXT_IRQ_PIN_A
        |=> VECTOR_REQ[0]) else $error("low level not requested");
    wake_cause_a: assert property ($rose(WAKE_UP) |-> POWER_DOWN &&
        ($past(WDT_TICK) || $past(WDT_TICK, 2))) else $error("wake without sample");
    wake_hold_a: assert property (WAKE_UP && POWER_DOWN |=> WAKE_UP)
        else $error("wake dropped in power-down");
    mask_gate_a: assert property (IRQ |-> $past(any_msk) || $past(any_msk, 2))
        else $error("irq while all masked");
    cover property (rd && PSLVERR);
    cover property ($rose(WAKE_UP));
    cover property ($rose(VECTOR_REQ[1]));
endmodule : epi_unit_checker
`default_nettype wire

// file: dv/epi_pin_src.sv
`timescale 1ns/1ps
`default_nettype none
module epi_pin_src (
    input  wire logic       SYS_CLK, // bench clock
    input  wire logic       slow,    // one extra cycle of lag
    input  wire logic [1:0] want,    // level asked for per pin
    output logic      [1:0] pins     // driven pin levels
);
    logic [1:0] lag = 2'h3;
    logic [1:0] now = 2'h3;
    assign pins = now;
    // levels change on whole cycles only, so every pulse spans clock periods
    always @(posedge SYS_CLK) begin
        lag <= want;
        now <= slow ? lag : want;
    end
endmodule : epi_pin_src
`default_nettype wire

// file: dv/tb_epi_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_epi_unit;
    import epi_pkg::*;
    logic        SYS_CLK, RESETN, PSEL, PENABLE, PWRITE, IO_CLK_RUN, POWER_DOWN, WDT_TICK;
    logic        PREADY, PSLVERR, WAKE_UP, IRQ, slow, err;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [1:0]  VECTOR_ACK, VECTOR_REQ, want, pins;
    int          mismatches, cmp_count;
    epi_unit #(.STARTUP_NS(100)) u_epi_unit (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_IRQ_PIN_A(pins[0]),
        .EXT_IRQ_PIN_B(pins[1]), .IO_CLK_RUN(IO_CLK_RUN), .POWER_DOWN(POWER_DOWN),
        .WDT_TICK(WDT_TICK), .VECTOR_ACK(VECTOR_ACK), .VECTOR_REQ(VECTOR_REQ),
        .WAKE_UP(WAKE_UP), .IRQ(IRQ));
    epi_pin_src u_epi_pin_src (.SYS_CLK(SYS_CLK), .slow(slow), .want(want), .pins(pins));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task stop_test;
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask : cyc
    // leading edge keeps the release of the previous transfer in its own step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge SYS_CLK);
        end while (!PREADY);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        apb(1'b0, ADDR_SENSE_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h40, 32'hFF);
        chk(err, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, ADDR_ENABLE_CTRL, 32'hFFFFFFFF);
        apb(1'b0, ADDR_ENABLE_CTRL, 32'h0);
        chk(rd, 32'hC3);
    endtask : t_regs
    task t_modes;
        int m;
        apb(1'b1, ADDR_CORE_STATUS, 32'h80);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        for (m = 0; m < 4; m++) begin
            slow <= m[0];
            apb(1'b1, ADDR_SENSE_CTRL, m);
            apb(1'b1, ADDR_FLAGS, 32'hC0);
            apb(1'b1, ADDR_IRQ_STATUS, 32'h3);
            want[0] <= 1'b0;
            cyc(8);
            apb(1'b0, ADDR_FLAGS, 32'h0);
            chk(rd[6], m == 1 || m == 2);
            chk(VECTOR_REQ[0], m != 3);
            chk(IRQ, m != 3);
            apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
            chk(rd, m != 3);
            apb(1'b1, ADDR_FLAGS, 32'hC0);
            want[0] <= 1'b1;
            cyc(8);
            apb(1'b0, ADDR_FLAGS, 32'h0);
            chk(rd[6], m == 1 || m == 3);
            chk(VECTOR_REQ[0], m == 1 || m == 3);
        end
    endtask : t_modes
    task t_gate;
        apb(1'b1, ADDR_CORE_STATUS, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        apb(1'b1, ADDR_SENSE_CTRL, 32'h2);
        want[0] <= 1'b0;
        cyc(8);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd[6], 32'h1);
        chk({VECTOR_REQ[0], IRQ}, 32'h0);
        apb(1'b1, ADDR_FLAGS, 32'hC0);
        want[0] <= 1'b1;
        cyc(8);
        // pulse ends at its starting level, so a frozen history sees no edge either
        IO_CLK_RUN <= 1'b0;
        want[0] <= 1'b0;
        cyc(6);
        want[0] <= 1'b1;
        cyc(6);
        IO_CLK_RUN <= 1'b1;
        cyc(8);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd[6], 32'h0);
        apb(1'b1, ADDR_CORE_STATUS, 32'h80);
    endtask : t_gate
    task t_chan_b;
        apb(1'b1, ADDR_SENSE_CTRL, 32'h0C);
        want[1] <= 1'b0;
        cyc(6);
        want[1] <= 1'b1;
        cyc(8);
        chk(VECTOR_REQ, 32'h2);
        VECTOR_ACK <= 2'h2;
        @(posedge SYS_CLK);
        VECTOR_ACK <= 2'h0;
        cyc(3);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk({rd[7:6], VECTOR_REQ}, 32'h0);
    endtask : t_chan_b
    task t_wake;
        int h;
        apb(1'b1, ADDR_SENSE_CTRL, 32'h0);
        for (h = 0; h < 2; h++) begin
            apb(1'b1, ADDR_IRQ_STATUS, 32'h3);
            POWER_DOWN <= 1'b1;
            IO_CLK_RUN <= 1'b0;
            want[0] <= 1'b0;
            cyc(2);
            repeat (2) begin
                WDT_TICK <= 1'b1;
                @(posedge SYS_CLK);
                WDT_TICK <= 1'b0;
                cyc(2);
            end
            chk(WAKE_UP, 32'h1);
            want[0] <= h == 0;
            cyc(12);
            chk(VECTOR_REQ[0], h == 1);
            apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
            chk(rd, h);
            POWER_DOWN <= 1'b0;
            IO_CLK_RUN <= 1'b1;
            want[0] <= 1'b1;
            cyc(8);
        end
    endtask : t_wake
    // ----------------------------------------
    // run
    // ----------------------------------------
    initial begin
        SYS_CLK = 1'b0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        #1000000;
        mismatches++;
        stop_test;
    end
    initial begin
        {RESETN, PSEL, PENABLE, PWRITE, POWER_DOWN, WDT_TICK, slow} = '0;
        {PADDR, PWDATA, VECTOR_ACK} = '0;
        IO_CLK_RUN = 1'b1;
        want = 2'h3;
        mismatches = 0;
        cmp_count = 0;
        cyc(6);
        RESETN <= 1'b1;
        t_regs;
        t_modes;
        t_gate;
        t_chan_b;
        t_wake;
        stop_test;
    end
endmodule : tb_epi_unit
bind epi_unit epi_unit_checker #(.STARTUP_NS(STARTUP_NS)) u_epi_unit_checker (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .EXT_IRQ_PIN_A(EXT_IRQ_PIN_A), .EXT_IRQ_PIN_B(EXT_IRQ_PIN_B), .IO_CLK_RUN(IO_CLK_RUN),
    .POWER_DOWN(POWER_DOWN), .WDT_TICK(WDT_TICK), .VECTOR_ACK(VECTOR_ACK),
    .VECTOR_REQ(VECTOR_REQ), .WAKE_UP(WAKE_UP), .IRQ(IRQ));
`default_nettype wire
